//--- common/emhq_map.svh
`ifndef EMHQ_MAP_SVH
`define EMHQ_MAP_SVH
`define EMHQ_OFF_CFG      8'h04
`define EMHQ_OFF_STATUS   8'h08
`define EMHQ_OFF_TXADDR   8'h0c
`define EMHQ_OFF_TXCTRL   8'h10
`define EMHQ_OFF_TXSTAT   8'h14
`define EMHQ_OFF_RXQPTR   8'h18
`define EMHQ_OFF_RXSTAT   8'h20
`define EMHQ_OFF_IRQSTAT  8'h24
`define EMHQ_OFF_IRQEN    8'h28
`define EMHQ_OFF_IRQDIS   8'h2c
`define EMHQ_OFF_IRQMASK  8'h30
`define EMHQ_CFG_RST      32'h0000_0800
`define EMHQ_CFG_CLK_LSB  10
`define EMHQ_CFG_RETRY_BIT 12
`define EMHQ_CFG_RMII_BIT 13
`define EMHQ_LENGTH_W     11
`define EMHQ_NOFCS_BIT    15
`define EMHQ_IRQ_W        12
`define EMHQ_MASK_RST     12'hfff
`define EMHQ_DIV_BASE     8
`endif

//--- common/emhq_pkg.sv
package emhq_pkg;
   typedef struct packed {
      logic [10:0] length;
      logic        no_fcs;
      logic [31:0] addr;
   } emhq_frame_s;
   typedef enum logic [1:0] {
      EMHQ_TX_IDLE,
      EMHQ_TX_SEND
   } emhq_tx_e;
   typedef struct packed {
      logic collision;
      logic retry_limit;
      logic frame_sent;
      logic underrun;
      logic abort;
   } emhq_txev_s;
   typedef struct packed {
      logic no_buffer;
      logic stored;
      logic overrun;
   } emhq_rxev_s;
endpackage : emhq_pkg

//--- testbench/emhq_phy_model.sv
`timescale 1ns/100ps
// ==========================================
// Far-side stand-in: transmit data path and line
// ==========================================
module emhq_phy_model #(
   parameter int SEND_CYC = 200
) (
   input  wire logic                 clock_in,
   input  wire logic                 srst_in,
   input  wire logic                 tx_start_in,
   input  wire logic                 fill_in,
   input  wire emhq_pkg::emhq_txev_s fault_in,
   output logic                      two_words_out,
   output emhq_pkg::emhq_txev_s      tx_event_out
);
   logic [8:0] cnt_q;
   logic       busy_q;
   // Two words count as loaded only while the bench lets the data path fill
   assign two_words_out = fill_in;
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         busy_q <= 1'b0;
         cnt_q  <= 9'h000;
      end else if (tx_start_in) begin
         busy_q <= 1'b1;
         cnt_q  <= 9'(SEND_CYC);
      end else if (busy_q) begin
         cnt_q <= cnt_q - 9'h001;
         if (cnt_q == 9'h001) begin
            busy_q <= 1'b0;
         end
      end
   end
   // Line faults come only when the bench commands them
   always_comb begin
      tx_event_out            = fault_in;
      tx_event_out.frame_sent = busy_q && (cnt_q == 9'h001);
   end
endmodule : emhq_phy_model

//--- testbench/ethernet_mac_host_queue_status_bench.sv
`timescale 1ns/100ps
`include "emhq_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %0t got=%h exp=%h", $time, g, e); end end
module ethernet_mac_host_queue_status_bench;
   logic clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, wreq, mclk, retry, rmii, start, act, badf, irq, two;
   logic mdio = 1'b0, busy = 1'b0, done = 1'b0, link = 1'b0, fill = 1'b0, adv = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0, q, rdata, nxt = 32'h0;
   emhq_pkg::emhq_txev_s  fault = '0, txev;
   emhq_pkg::emhq_rxev_s  rxev = '0;
   emhq_pkg::emhq_frame_s frm;
   int failures = 0, n_checks = 0, starts = 0, cyc = 0;
   emhq_top emhq_top_i (.clock_in(clk), .srst_in(srst), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq), .mdio_pin_in(mdio), .mgmt_busy_in(busy), .mgmt_done_in(done),
      .link_pin_in(link), .tx_event_in(txev), .tx_fifo_two_words_in(two), .tx_fifo_base_in(32'h3000_0010),
      .rx_event_in(rxev), .rx_ptr_advance_in(adv), .rx_ptr_next_in(nxt), .mgmt_clk_out(mclk),
      .retry_test_out(retry), .rmii_mode_out(rmii), .tx_start_out(start), .tx_frame_out(frm),
      .tx_active_out(act), .tx_bad_fcs_out(badf), .irq_out(irq));
   emhq_phy_model #(.SEND_CYC(200)) emhq_phy_model_i (.clock_in(clk), .srst_in(srst), .tx_start_in(start),
      .fill_in(fill), .fault_in(fault), .two_words_out(two), .tx_event_out(txev));
   initial forever #20 clk = ~clk;
   // ==========================================
   // Watchdog and launch counter
   // ==========================================
   always @(posedge clk) begin
      cyc++;
      if (start === 1'b1) starts++;
      if (cyc == 40000) begin
         failures++;
         final_report();
      end
   end
   task final_report;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   // ==========================================
   // Bus and pulse helpers
   // ==========================================
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wr  <= w;
      rd  <= ~w;
      wd  <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   task idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle
   // Extra edge at the end so registered reactions have landed on return
   task txp(input logic [4:0] e);
      @(posedge clk) fault <= e;
      @(posedge clk) fault <= '0;
      @(posedge clk);
   endtask : txp
   task rxp(input logic [2:0] e);
      @(posedge clk) rxev <= e;
      @(posedge clk) rxev <= '0;
      @(posedge clk);
   endtask : rxp
   task rise(output int n);
      logic p;
      n = 0;
      do begin
         p = mclk;
         @(posedge clk);
         n++;
      end while (p !== 1'b0 || mclk !== 1'b1);
   endtask : rise
   // ==========================================
   // Scenarios
   // ==========================================
   task t_cfg;
      int n;
      bus(0, `EMHQ_OFF_CFG, 0);
      `CHK(q, `EMHQ_CFG_RST)
      for (int s = 0; s < 4; s++) begin
         bus(1, `EMHQ_OFF_CFG, 32'((s << 10) | ((s & 1) << 12) | ((s >> 1) << 13)));
         `CHK(retry, 1'(s & 1))
         `CHK(rmii, 1'(s >> 1))
         rise(n);
         rise(n);
         rise(n);
         `CHK(n, 8 << s)
      end
      bus(1, `EMHQ_OFF_CFG, `EMHQ_CFG_RST);
   endtask : t_cfg
   task t_stat;
      mdio <= 1'b1;
      bus(0, `EMHQ_OFF_STATUS, 0);
      `CHK(q, 32'h0000_0002)
      mdio <= 1'b0;
      busy <= 1'b1;
      bus(0, `EMHQ_OFF_STATUS, 0);
      `CHK(q, 32'h0000_0004)
      busy <= 1'b0;
   endtask : t_stat
   task t_rx;
      bus(0, `EMHQ_OFF_IRQSTAT, 0);
      bus(1, `EMHQ_OFF_RXQPTR, 32'h0000_1003);
      bus(0, `EMHQ_OFF_RXQPTR, 0);
      `CHK(q, 32'h0000_1000)
      @(posedge clk) {adv, nxt} <= {1'b1, 32'h0000_4000};
      @(posedge clk) adv <= 1'b0;
      rxp(3'b100);
      rxp(3'b100);
      rxp(3'b010);
      rxp(3'b001);
      bus(0, `EMHQ_OFF_RXQPTR, 0);
      `CHK(q, 32'h0000_4000)
      bus(0, `EMHQ_OFF_RXSTAT, 0);
      `CHK(q, 32'h0000_0007)
      bus(1, `EMHQ_OFF_RXSTAT, 32'h0000_0007);
      bus(0, `EMHQ_OFF_RXSTAT, 0);
      `CHK(q, 32'h0000_0000)
      bus(0, `EMHQ_OFF_IRQSTAT, 0);
      `CHK(q, 32'h0000_0406)
   endtask : t_rx
   task t_tx;
      bus(0, `EMHQ_OFF_IRQSTAT, 0);
      // A zero length must not queue anything
      bus(1, `EMHQ_OFF_TXCTRL, 32'h0000_8000);
      bus(0, `EMHQ_OFF_TXSTAT, 0);
      `CHK(q, 32'h0000_0018)
      bus(1, `EMHQ_OFF_TXADDR, 32'h2000_0002);
      bus(1, `EMHQ_OFF_TXCTRL, 32'h0000_8640);
      bus(0, `EMHQ_OFF_TXSTAT, 0);
      `CHK(q[3], 1'b0)
      idle(10);
      `CHK(starts, 0)
      fill <= 1'b1;
      for (int i = 0; i < 20 && starts == 0; i++) @(posedge clk);
      `CHK(frm, {11'h640, 1'b1, 32'h2000_0002})
      `CHK(act, 1'b1)
      bus(0, `EMHQ_OFF_TXCTRL, 0);
      `CHK(q, 32'h0000_8640)
      bus(0, `EMHQ_OFF_TXADDR, 0);
      `CHK(q, 32'h3000_0010)
      bus(1, `EMHQ_OFF_TXADDR, 32'h2100_0000);
      bus(1, `EMHQ_OFF_TXCTRL, 32'h0000_0040);
      bus(0, `EMHQ_OFF_TXSTAT, 0);
      `CHK(q[4], 1'b0)
      bus(1, `EMHQ_OFF_TXADDR, 32'h2200_0000);
      bus(1, `EMHQ_OFF_TXCTRL, 32'h0000_0080);
      bus(0, `EMHQ_OFF_TXSTAT, 0);
      `CHK(q[0], 1'b1)
      bus(1, `EMHQ_OFF_TXSTAT, 32'h0000_0001);
      bus(0, `EMHQ_OFF_TXSTAT, 0);
      `CHK(q[0], 1'b0)
      txp(5'b10000);
      txp(5'b01000);
      txp(5'b00010);
      `CHK(badf, 1'b1)
      bus(0, `EMHQ_OFF_TXSTAT, 0);
      `CHK(q[6:0], 7'h46)
      bus(1, `EMHQ_OFF_TXSTAT, 32'h0000_0046);
      bus(0, `EMHQ_OFF_TXSTAT, 0);
      `CHK(q[6:0], 7'h00)
      for (int i = 0; i < 400 && starts < 2; i++) @(posedge clk);
      `CHK(frm, {11'h040, 1'b0, 32'h2100_0000})
      bus(0, `EMHQ_OFF_TXCTRL, 0);
      `CHK(q, 32'h0000_0040)
      for (int i = 0; i < 400 && act !== 1'b0; i++) @(posedge clk);
      bus(0, `EMHQ_OFF_TXSTAT, 0);
      `CHK(q[6:0], 7'h38)
      bus(0, `EMHQ_OFF_IRQSTAT, 0);
      `CHK(q, 32'h0000_01f8)
      fill <= 1'b0;
   endtask : t_tx
   task t_irq;
      bus(0, `EMHQ_OFF_IRQSTAT, 0);
      bus(0, `EMHQ_OFF_IRQMASK, 0);
      `CHK(q, 32'h0000_0fff)
      @(posedge clk) {done, link} <= 2'b11;
      @(posedge clk) done <= 1'b0;
      txp(5'b00001);
      `CHK(irq, 1'b0)
      bus(1, `EMHQ_OFF_IRQEN, 32'h0000_0201);
      bus(0, `EMHQ_OFF_IRQMASK, 0);
      `CHK(q, 32'h0000_0dfe)
      idle(2);
      `CHK(irq, 1'b1)
      bus(1, `EMHQ_OFF_IRQDIS, 32'h0000_0201);
      idle(2);
      `CHK(irq, 1'b0)
      bus(1, `EMHQ_OFF_IRQEN, 32'h0000_0001);
      bus(0, `EMHQ_OFF_IRQSTAT, 0);
      `CHK(q, 32'h0000_0a01)
      idle(2);
      `CHK(irq, 1'b0)
      bus(0, 8'h1c, 0);
      `CHK(q, 32'h0000_0000)
      link <= 1'b0;
   endtask : t_irq
   initial begin
      idle(2);
      srst <= 1'b0;
      t_cfg();
      t_stat();
      t_rx();
      t_tx();
      t_irq();
      final_report();
   end
endmodule : ethernet_mac_host_queue_status_bench

//--- verilog/emhq_top.sv
`timescale 1ns/100ps
`include "emhq_map.svh"
module emhq_top (
   input  wire logic                 clock_in,
   input  wire logic                 srst_in,
   input  wire logic [7:0]           avs_address_in,
   input  wire logic                 avs_read_in,
   input  wire logic                 avs_write_in,
   input  wire logic [31:0]          avs_writedata_in,
   input  wire logic [3:0]           avs_byteenable_in,
   output logic      [31:0]          avs_readdata_out,
   output logic                      avs_waitrequest_out,
   input  wire logic                 mdio_pin_in,
   input  wire logic                 mgmt_busy_in,
   input  wire logic                 mgmt_done_in,
   input  wire logic                 link_pin_in,
   input  wire emhq_pkg::emhq_txev_s tx_event_in,
   input  wire logic                 tx_fifo_two_words_in,
   input  wire logic [31:0]          tx_fifo_base_in,
   input  wire emhq_pkg::emhq_rxev_s rx_event_in,
   input  wire logic                 rx_ptr_advance_in,
   input  wire logic [31:0]          rx_ptr_next_in,
   output logic                      mgmt_clk_out,
   output logic                      retry_test_out,
   output logic                      rmii_mode_out,
   output logic                      tx_start_out,
   output emhq_pkg::emhq_frame_s     tx_frame_out,
   output logic                      tx_active_out,
   output logic                      tx_bad_fcs_out,
   output logic                      irq_out
);
   // ==========================================================
   // Bus slave
   // ==========================================================
   // One wait state: the answer is registered, so reads see state of the request edge.
   logic        ack_q;
   logic        acc;
   logic        wr;
   logic        rd;
   logic [31:0] wdata;
   assign acc   = (avs_read_in | avs_write_in) & ~ack_q;
   assign wr    = avs_write_in & acc;
   assign rd    = avs_read_in & acc;
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
   assign wdata = avs_writedata_in & {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                                      {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc;
      end
   end

   // ==========================================================
   // Configuration and management clock
   // ==========================================================
   logic [31:0] cfg_q;
   logic [5:0]  div_q;
   logic [6:0]  div_lim;
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         cfg_q <= `EMHQ_CFG_RST;
      end else if (wr && avs_address_in == `EMHQ_OFF_CFG) begin
         cfg_q <= wdata & 32'h0000_3c00;
      end
   end
   assign retry_test_out = cfg_q[`EMHQ_CFG_RETRY_BIT];
   assign rmii_mode_out  = cfg_q[`EMHQ_CFG_RMII_BIT];
   // Half period in system clocks: 4,8,16,32
   assign div_lim = 7'((`EMHQ_DIV_BASE / 2) << cfg_q[`EMHQ_CFG_CLK_LSB +: 2]);
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         div_q        <= 6'h00;
         mgmt_clk_out <= 1'b0;
      end else if ({1'b0, div_q} >= div_lim - 7'h01) begin
         div_q        <= 6'h00;
         mgmt_clk_out <= ~mgmt_clk_out;
      end else begin
         div_q <= div_q + 6'h01;
      end
   end

   // ==========================================================
   // Transmit queue
   // ==========================================================
   // Address staged first, then latched with length into the one-deep slot.
   emhq_pkg::emhq_tx_e    tx_st_q;
   emhq_pkg::emhq_frame_s cur_q;
   emhq_pkg::emhq_frame_s pend_q;
   logic                  pend_v_q;
   logic [31:0]           addr_stage_q;
   logic                  w_addr;
   logic                  w_ctrl;
   logic                  length_nz;
   logic                  q_free;
   logic                  launch;
   assign w_addr    = wr && avs_address_in == `EMHQ_OFF_TXADDR;
   assign w_ctrl    = wr && avs_address_in == `EMHQ_OFF_TXCTRL;
   assign length_nz = |wdata[`EMHQ_LENGTH_W-1:0];
   assign q_free    = ~pend_v_q;
   // Start only with two words loaded; no upper length limit is enforced
   assign launch    = pend_v_q & tx_fifo_two_words_in & (tx_st_q == emhq_pkg::EMHQ_TX_IDLE);
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         addr_stage_q <= 32'h0000_0000;
      end else if (w_addr && q_free) begin
         addr_stage_q <= avs_writedata_in;
      end
   end
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pend_q   <= '0;
         pend_v_q <= 1'b0;
      end else if (w_ctrl && q_free && length_nz) begin
         pend_q.length <= wdata[`EMHQ_LENGTH_W-1:0];
         pend_q.no_fcs <= wdata[`EMHQ_NOFCS_BIT];
         pend_q.addr   <= addr_stage_q;
         pend_v_q      <= 1'b1;
      end else if (launch) begin
         pend_v_q <= 1'b0;
      end
   end
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         tx_st_q <= emhq_pkg::EMHQ_TX_IDLE;
         cur_q   <= '0;
      end else begin
         case (tx_st_q)
            emhq_pkg::EMHQ_TX_IDLE: begin
               if (launch) begin
                  cur_q   <= pend_q;
                  tx_st_q <= emhq_pkg::EMHQ_TX_SEND;
               end
            end
            emhq_pkg::EMHQ_TX_SEND: begin
               if (tx_event_in.frame_sent) begin
                  tx_st_q <= emhq_pkg::EMHQ_TX_IDLE;
               end
            end
            default: tx_st_q <= emhq_pkg::EMHQ_TX_IDLE;
         endcase
      end
   end
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         tx_start_out <= 1'b0;
      end else begin
         tx_start_out <= launch;
      end
   end
   assign tx_frame_out  = cur_q;
   assign tx_active_out = (tx_st_q == emhq_pkg::EMHQ_TX_SEND);
   logic tx_idle;
   assign tx_idle = ~pend_v_q & ~tx_active_out;
   // Bad CRC forced for the rest of the frame after underrun
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         tx_bad_fcs_out <= 1'b0;
      end else if (launch) begin
         tx_bad_fcs_out <= 1'b0;
      end else if (tx_event_in.underrun && tx_active_out) begin
         tx_bad_fcs_out <= 1'b1;
      end
   end

   // ==========================================================
   // Transmit status flags (write one to clear, set wins)
   // ==========================================================
   // Bits 0 to 3 hold collision, retry limit, complete and underrun
   logic [3:0] tflg_q;
   logic       tx_overrun_q;
   logic       w_tsr;
   logic       tx_overrun_set;
   assign w_tsr          = wr && avs_address_in == `EMHQ_OFF_TXSTAT;
   assign tx_overrun_set = (w_addr | w_ctrl) & ~q_free;
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         tx_overrun_q <= 1'b0;
      end else begin
         tx_overrun_q <= tx_overrun_set | (tx_overrun_q & ~(w_tsr & wdata[0]));
      end
   end
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         tflg_q <= 4'h0;
      end else begin
         tflg_q[0] <= tx_event_in.collision   | (tflg_q[0] & ~(w_tsr & wdata[1]));
         tflg_q[1] <= tx_event_in.retry_limit | (tflg_q[1] & ~(w_tsr & wdata[2]));
         tflg_q[2] <= tx_event_in.frame_sent  | (tflg_q[2] & ~(w_tsr & wdata[5]));
         tflg_q[3] <= tx_event_in.underrun    | (tflg_q[3] & ~(w_tsr & wdata[6]));
      end
   end

   // ==========================================================
   // Receive pointer and status
   // ==========================================================
   logic [31:0] rxq_q;
   logic [2:0]  rflg_q;
   logic        w_rsr;
   assign w_rsr = wr && avs_address_in == `EMHQ_OFF_RXSTAT;
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rxq_q <= 32'h0000_0000;
      end else if (wr && avs_address_in == `EMHQ_OFF_RXQPTR) begin
         rxq_q <= {avs_writedata_in[31:2], 2'b00};
      end else if (rx_ptr_advance_in) begin
         rxq_q <= {rx_ptr_next_in[31:2], 2'b00};
      end
   end
   // Every failed fetch sets it again, even without a good fetch since the clear
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         rflg_q <= 3'h0;
      end else begin
         rflg_q[0] <= rx_event_in.no_buffer | (rflg_q[0] & ~(w_rsr & wdata[0]));
         rflg_q[1] <= rx_event_in.stored    | (rflg_q[1] & ~(w_rsr & wdata[1]));
         rflg_q[2] <= rx_event_in.overrun   | (rflg_q[2] & ~(w_rsr & wdata[2]));
      end
   end

   // ==========================================================
   // Interrupt status and mask
   // ==========================================================
   logic [`EMHQ_IRQ_W-1:0] isr_q;
   logic [`EMHQ_IRQ_W-1:0] imr_q;
   logic [`EMHQ_IRQ_W-1:0] iev;
   logic                   idle_d1_q;
   logic                   free_d1_q;
   logic                   link_d1_q;
   logic                   rd_isr;
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         idle_d1_q <= 1'b1;
         free_d1_q <= 1'b1;
         link_d1_q <= link_pin_in;
      end else begin
         idle_d1_q <= tx_idle;
         free_d1_q <= q_free;
         link_d1_q <= link_pin_in;
      end
   end
   assign iev = {tx_event_in.abort,
                 rx_event_in.overrun,
                 link_pin_in ^ link_d1_q,
                 tx_idle & ~idle_d1_q,
                 tx_event_in.frame_sent,
                 q_free & ~free_d1_q,
                 tx_event_in.retry_limit,
                 tx_event_in.underrun,
                 tx_overrun_set,
                 rx_event_in.no_buffer,
                 rx_event_in.stored,
                 mgmt_done_in};
   assign rd_isr = rd && avs_address_in == `EMHQ_OFF_IRQSTAT;
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         isr_q <= '0;
      end else begin
         isr_q <= iev | (isr_q & {`EMHQ_IRQ_W{~rd_isr}});
      end
   end
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         imr_q <= `EMHQ_MASK_RST;
      end else if (wr && avs_address_in == `EMHQ_OFF_IRQEN) begin
         imr_q <= imr_q & ~wdata[`EMHQ_IRQ_W-1:0];
      end else if (wr && avs_address_in == `EMHQ_OFF_IRQDIS) begin
         imr_q <= imr_q | wdata[`EMHQ_IRQ_W-1:0];
      end
   end
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(isr_q & ~imr_q);
      end
   end

   // ==========================================================
   // Read data
   // ==========================================================
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (rd) begin
         case (avs_address_in)
            `EMHQ_OFF_CFG:     avs_readdata_out <= cfg_q;
            `EMHQ_OFF_STATUS:  avs_readdata_out <= {29'h0, mgmt_busy_in, mdio_pin_in, 1'b0};
            `EMHQ_OFF_TXADDR:  avs_readdata_out <= tx_fifo_base_in;
            `EMHQ_OFF_TXCTRL:  avs_readdata_out <= {16'h0, cur_q.no_fcs, 4'h0, cur_q.length};
            `EMHQ_OFF_TXSTAT:  avs_readdata_out <= {25'h0, tflg_q[3], tflg_q[2], q_free, tx_idle,
                                                   tflg_q[1], tflg_q[0], tx_overrun_q};
            `EMHQ_OFF_RXQPTR:  avs_readdata_out <= rxq_q;
            `EMHQ_OFF_RXSTAT:  avs_readdata_out <= {29'h0, rflg_q[2], rflg_q[1], rflg_q[0]};
            `EMHQ_OFF_IRQSTAT: avs_readdata_out <= {20'h0, isr_q};
            `EMHQ_OFF_IRQMASK: avs_readdata_out <= {20'h0, imr_q};
            default:           avs_readdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   property p_wait_one;
      @(posedge clock_in) disable iff (srst_in) $rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest not one cycle");
   property p_tx_overrun;
      @(posedge clock_in) disable iff (srst_in) ((w_addr || w_ctrl) && !q_free) |=> tx_overrun_q;
   endproperty
   a_tx_overrun: assert property (p_tx_overrun) else $error("tx overrun not set");
   property p_queue;
      @(posedge clock_in) disable iff (srst_in) (w_ctrl && q_free && length_nz) |=> !q_free && !tx_idle;
   endproperty
   a_queue: assert property (p_queue) else $error("length write did not queue");
   property p_two_words;
      @(posedge clock_in) disable iff (srst_in) tx_start_out |-> $past(tx_fifo_two_words_in);
   endproperty
   a_two_words: assert property (p_two_words) else $error("start without two words");
   property p_rx_align;
      @(posedge clock_in) disable iff (srst_in) rxq_q[1:0] == 2'b00;
   endproperty
   a_rx_align: assert property (p_rx_align) else $error("rx pointer misaligned");
   property p_isr_clear;
      @(posedge clock_in) disable iff (srst_in) (rd_isr && iev == '0) |=> isr_q == '0;
   endproperty
   a_isr_clear: assert property (p_isr_clear) else $error("isr not cleared on read");
   property p_irq;
      @(posedge clock_in) disable iff (srst_in) |(isr_q & ~imr_q) |=> irq_out;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   property p_no_buf;
      @(posedge clock_in) disable iff (srst_in) rx_event_in.no_buffer |=> rflg_q[0];
   endproperty
   a_no_buf: assert property (p_no_buf) else $error("no-buffer flag lost");
   property p_col;
      @(posedge clock_in) disable iff (srst_in) tx_event_in.collision |=> tflg_q[0];
   endproperty
   a_col: assert property (p_col) else $error("collision flag lost");
endmodule : emhq_top
